/* File: hw/io_space_decode_gp_regs.sv */
// i/o space decoder with scratch bank and one flag register
// assumes the core holds op/address/data valid for one cycle
`timescale 1ns/10ps
`include "io_space_params.svh"
module io_space_decode_gp_regs
	import io_space_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// core access
	input wire io_op_e op,
	input wire logic [7:0] addr,
	input wire logic [2:0] bitSel,
	input wire logic [7:0] wrData,
	// flag event sources, same clock domain
	input wire logic [7:0] flagSet,
	// answers
	output logic [7:0] rdData,
	output logic rdValid,
	output logic skipTaken,
	output logic [7:0] flagStatus
);
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] bankRd;
	logic [7:0] bankPeek;
	logic [7:0] bankWrData;
	logic [2:0] rdSrc;
	logic [2:0] bitReg;
	logic testPending;

	// port ops see a six-bit address
	wire portOp = (op == OP_PORT_RD) || (op == OP_PORT_WR);
	wire bitOp = (op == OP_BIT_SET) || (op == OP_BIT_CLR) ||
		(op == OP_BIT_TEST);
	wire dataOp = (op == OP_DATA_RD) || (op == OP_DATA_WR);
	// data address minus offset gives i/o address
	wire [7:0] dataIo = addr - `IO_DATA_OFFSET;
	// extended area and memory never map here
	wire dataHit = dataOp && (addr >= `IO_DATA_OFFSET) &&
		(addr < `IO_EXT_LOW);
	wire bitHit = bitOp && (addr[7:5] == 3'b000);
	wire portHit = portOp && (addr[7:6] == 2'b00);
	wire [5:0] ioAddr = dataOp ? dataIo[5:0] : addr[5:0];
	wire anyHit = dataHit || bitHit || portHit;
	wire isWrite = (op == OP_PORT_WR) || (op == OP_DATA_WR);
	wire isRead = (op == OP_PORT_RD) || (op == OP_DATA_RD);
	wire isFlag = anyHit && (ioAddr == `FLAG_ADDR);
	wire [7:0] bitMask = 8'h01 << bitSel;

	function automatic logic [2:0] scratchSel(input logic [5:0] a);
		unique case (a)
			`SCRATCH_ADDR_0: scratchSel = 3'b100;
			`SCRATCH_ADDR_1: scratchSel = 3'b101;
			`SCRATCH_ADDR_2: scratchSel = 3'b110;
			`SCRATCH_ADDR_3: scratchSel = 3'b111;
			default: scratchSel = 3'b000;
		endcase
	endfunction : scratchSel

	wire [2:0] sel = scratchSel(ioAddr);
	wire isScratch = anyHit && sel[2];
	// bit ops rewrite only the chosen bit
	always_comb
	begin
		bankWrData = wrData;
		if (op == OP_BIT_SET)
			bankWrData = bankPeek | bitMask;
		else if (op == OP_BIT_CLR)
			bankWrData = bankPeek & ~bitMask;
	end
	wire bankWr = isScratch && (isWrite || op == OP_BIT_SET ||
		op == OP_BIT_CLR);

	scratch_bank #(.DEPTH(4)) bank (
		.clock(clock),
		.rst(rst),
		.wrEn(bankWr),
		.wrIndex(sel[1:0]),
		.wrData(bankWrData),
		.rdIndex(sel[1:0]),
		.rdData(bankRd),
		.peekData(bankPeek)
	);

	// write one clears, set wins over clear
	always_comb
	begin
		next_flags = flags;
		if (isFlag && isWrite)
			next_flags = flags & ~wrData;
		// bit set on a flag clears that bit only
		else if (isFlag && op == OP_BIT_SET)
			next_flags = flags & ~bitMask;
		next_flags = next_flags | flagSet;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			flags <= `FLAG_RESET;
		else
			flags <= next_flags;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rdSrc <= 3'b000;
			rdValid <= 1'b0;
			testPending <= 1'b0;
			bitReg <= 3'b000;
		end
		else
		begin
			rdValid <= isRead;
			testPending <= (op == OP_BIT_TEST);
			bitReg <= bitSel;
			// reads select source by decoded location
			rdSrc <= (isRead || op == OP_BIT_TEST) ?
				{isScratch, isFlag, 1'b1} : 3'b000;
		end
	end

	wire [7:0] flagsHeld;
	logic [7:0] flagsLate;
	always_ff @(posedge clock)
	begin
		if (rst)
			flagsLate <= 8'h00;
		else
			flagsLate <= flags;
	end
	assign flagsHeld = flagsLate;
	wire [7:0] readMux = rdSrc[2] ? bankRd :
		(rdSrc[1] ? flagsHeld : 8'h00);

	// outputs registered one stage after the data settles
	logic [7:0] rdOut;
	logic skipOut;
	logic validOut;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rdOut <= 8'h00;
			skipOut <= 1'b0;
			validOut <= 1'b0;
			flagStatus <= `FLAG_RESET;
		end
		else
		begin
			rdOut <= rdValid ? readMux : 8'h00;
			skipOut <= testPending && readMux[bitReg];
			validOut <= rdValid;
			flagStatus <= flags;
		end
	end
	always_comb
	begin
		rdData = rdOut;
		skipTaken = skipOut;
	end

	logic validSeen;
	always_ff @(posedge clock)
	begin
		if (rst)
			validSeen <= 1'b0;
		else
			validSeen <= validOut;
	end

	a_unmapped_write_ignored: assert property (@(posedge clock)
		disable iff (rst) (isWrite && !anyHit) |-> !bankWr ##1
		(flags == ($past(flags) | $past(flagSet))))
		else $error("write to unmapped location changed state");
	a_flag_w1c: assert property (@(posedge clock)
		disable iff (rst) (isFlag && isWrite && flagSet == 8'h00) |=>
		((flags & $past(wrData)) == 8'h00))
		else $error("write-one did not clear flag");
	a_flag_zero_keeps: assert property (@(posedge clock)
		disable iff (rst) (isFlag && isWrite) |=>
		((flags & ~$past(wrData)) == ($past(flags) & ~$past(wrData)
		| $past(flagSet) & ~$past(wrData))))
		else $error("writing zero changed a flag");
	a_set_wins: assert property (@(posedge clock)
		disable iff (rst) (flagSet != 8'h00) |=>
		((flags & $past(flagSet)) == $past(flagSet)))
		else $error("flag event lost");
	a_ext_no_hit: assert property (@(posedge clock)
		disable iff (rst) (dataOp && addr >= `IO_EXT_LOW) |-> !anyHit)
		else $error("extended address decoded as i/o");
	a_bit_range: assert property (@(posedge clock)
		disable iff (rst) (bitOp && addr > 8'h1F) |-> !anyHit)
		else $error("bit op above range decoded");
	a_port_range: assert property (@(posedge clock)
		disable iff (rst) (portOp && addr > `IO_PORT_TOP) |-> !anyHit)
		else $error("port op above range decoded");
	a_data_offset: assert property (@(posedge clock)
		disable iff (rst) dataHit |-> (ioAddr == 6'(addr - 8'h20)))
		else $error("data offset mapping wrong");
	a_read_latency: assert property (@(posedge clock)
		disable iff (rst) isRead |-> ##2 validOut)
		else $error("read answer missing after two cycles");
	a_unmapped_reads_zero: assert property (@(posedge clock)
		disable iff (rst) (isRead && !anyHit) |-> ##2 (rdOut == 8'h00))
		else $error("unmapped read not zero");
	a_bit_op_mask: assert property (@(posedge clock)
		disable iff (rst) (bankWr && (op == OP_BIT_SET || op == OP_BIT_CLR))
		|-> ((((bankWrData ^ bankPeek) & ~bitMask) == 8'h00) &&
		(bankWrData[bitSel] == (op == OP_BIT_SET))))
		else $error("bit op rewrote another bit");
	a_skip_needs_test: assert property (@(posedge clock)
		disable iff (rst) skipOut |-> $past(testPending))
		else $error("skip raised without a bit test");

	c_scratch_write: cover property (@(posedge clock) bankWr);
	c_bit_set_flag: cover property (@(posedge clock)
		isFlag && op == OP_BIT_SET);
	c_skip: cover property (@(posedge clock) skipOut);
	c_read_back: cover property (@(posedge clock) validSeen);
endmodule : io_space_decode_gp_regs

/* File: hw/io_space_params.svh */
// constants for the i/o register space decoder and scratch bank
// assumes a single core-side access port per cycle
// Notes on behaviour
// - four 8-bit scratch registers, reset zero
// - low 32 i/o locations allow bit ops
// - port instructions use six-bit i/o address
// - data address equals i/o address plus 0x20
// - all i/o reachable by data load/store
// - extended 0x60-0xFF reachable by data only
// - some flags clear by writing one
// - bit set/clear touches only addressed bit
`ifndef IO_SPACE_PARAMS_SVH
`define IO_SPACE_PARAMS_SVH

`define IO_DATA_OFFSET 8'h20
`define IO_PORT_TOP 8'h3F
`define IO_BIT_TOP 6'h1F
`define IO_EXT_LOW 8'h60
`define SCRATCH_ADDR_0 6'h1E
`define SCRATCH_ADDR_1 6'h1A
`define SCRATCH_ADDR_2 6'h1B
`define SCRATCH_ADDR_3 6'h1C
`define FLAG_ADDR 6'h1D
`define SCRATCH_RESET 8'h00
`define FLAG_RESET 8'h00

`endif

/* File: hw/io_space_pkg.sv */
// types for the i/o register space decoder
// assumes io_space_params.svh supplies the numbers
package io_space_pkg;
	typedef enum logic [2:0]
	{
		OP_NONE = 3'b000,
		OP_PORT_RD = 3'b001,
		OP_PORT_WR = 3'b010,
		OP_DATA_RD = 3'b011,
		OP_DATA_WR = 3'b100,
		OP_BIT_SET = 3'b101,
		OP_BIT_CLR = 3'b110,
		OP_BIT_TEST = 3'b111
	} io_op_e;
endpackage : io_space_pkg

/* File: hw/scratch_bank.sv */
// four-entry byte memory holding the scratch registers
// assumes one write and one read index per cycle
`timescale 1ns/10ps
`include "io_space_params.svh"
module scratch_bank
	import io_space_pkg::*;
#(
	parameter int DEPTH = 4
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// write side
	input wire logic wrEn,
	input wire logic [1:0] wrIndex,
	input wire logic [7:0] wrData,
	// read side
	input wire logic [1:0] rdIndex,
	output logic [7:0] rdData,
	output logic [7:0] peekData
);
	logic [7:0] store [DEPTH];

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				store[i] <= `SCRATCH_RESET;
		end
		else if (wrEn)
			store[wrIndex] <= wrData;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			rdData <= 8'h00;
		else
			rdData <= store[rdIndex];
	end

	// combinational view used for read-modify-write
	assign peekData = store[rdIndex];
endmodule : scratch_bank

/* File: verification/core_model.sv */
// cpu core stand-in driving the i/o access port of the decoder
// assumes callers enter access just after a rising edge
`timescale 1ns/10ps
module core_model
	import io_space_pkg::*;
(
	// clock
	input wire logic clock,
	// access request
	output io_op_e op,
	output logic [7:0] addr,
	output logic [2:0] bitSel,
	output logic [7:0] wrData,
	// answers
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic skipTaken
);
	// strobes seen in the wrong cycle, read by the bench at the end
	int strobeMiss = 0;

	initial
	begin
		op = OP_NONE;
		addr = 8'h00;
		bitSel = 3'h0;
		wrData = 8'h00;
	end

	// reserved places written only by tests
	task automatic access(input io_op_e o, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d,
		output logic [7:0] rd, output logic sk);
		op = o;
		addr = a;
		bitSel = b;
		wrData = d;
		@(posedge clock);
		#1;
		// leftovers inverted so stale values never look valid
		op = OP_NONE;
		addr = ~a;
		wrData = ~d;
		// internal read stage stands the cycle after the request
		if (rdValid !== (o == OP_PORT_RD || o == OP_DATA_RD))
			strobeMiss++;
		// answers stand exactly one cycle, two edges on
		@(posedge clock);
		#1;
		rd = rdData;
		sk = skipTaken;
		@(posedge clock);
		#1;
		if (rdData !== 8'h00 || skipTaken !== 1'b0)
			strobeMiss++;
		@(posedge clock);
		#1;
	endtask : access
endmodule : core_model

/* File: verification/testbench.sv */
// self-checking bench for the i/o space decoder
// assumes core_model issues one access at a time
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module testbench
	import io_space_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] flagSet = 8'h00;
	io_op_e op;
	logic [7:0] addr;
	logic [2:0] bitSel;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic skipTaken;
	logic rdValid;
	logic [7:0] flagStatus;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [7:0] sc [4];
	logic [7:0] rd;
	logic sk;
	localparam logic [7:0] IOA [4] = '{8'h1E, 8'h1A, 8'h1B, 8'h1C};
	localparam io_op_e BOP [5] = '{OP_PORT_WR, OP_DATA_WR, OP_DATA_WR,
		OP_BIT_SET, OP_PORT_WR};
	localparam logic [7:0] BAD [5] = '{8'h5E, 8'h1E, 8'h7E, 8'h3E, 8'h10};

	always #10 clock = ~clock;

	io_space_decode_gp_regs dut_u (.clock(clock), .rst(rst), .op(op),
		.addr(addr), .bitSel(bitSel), .wrData(wrData), .flagSet(flagSet),
		.rdData(rdData), .rdValid(rdValid), .skipTaken(skipTaken),
		.flagStatus(flagStatus));

	core_model cpu_u (.clock(clock), .op(op), .addr(addr), .bitSel(bitSel),
		.wrData(wrData), .rdData(rdData), .rdValid(rdValid),
		.skipTaken(skipTaken));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			wrap_up();
		end
	end

	initial
	begin
		int k;
		logic [7:0] v;
		logic [2:0] b;
		void'($urandom(32'h2c9d));
		repeat (8) @(posedge clock);
		#1;
		rst = 1'b0;
		for (k = 0; k < 4; k++)
		begin
			cpu_u.access(OP_DATA_RD, IOA[k] + 8'h20, 3'h0, 8'h00, rd, sk);
			`CHK("reset value", 8'h00, rd)
			sc[k] = 8'h00;
		end
		repeat (24)
		begin
			k = $urandom_range(3);
			v = 8'($urandom);
			b = 3'($urandom);
			if (v[0])
				cpu_u.access(OP_PORT_WR, IOA[k], 3'h0, v, rd, sk);
			else
				cpu_u.access(OP_DATA_WR, IOA[k] + 8'h20, 3'h0, v, rd, sk);
			sc[k] = v;
			cpu_u.access(v[1] ? OP_BIT_SET : OP_BIT_CLR, IOA[k], b, v, rd, sk);
			sc[k][b] = v[1];
			if (v[0])
				cpu_u.access(OP_DATA_RD, IOA[k] + 8'h20, 3'h0, 8'h00, rd, sk);
			else
				cpu_u.access(OP_PORT_RD, IOA[k], 3'h0, 8'h00, rd, sk);
			`CHK("readback", sc[k], rd)
			cpu_u.access(OP_BIT_TEST, IOA[k], b, 8'h00, rd, sk);
			`CHK("bit test", sc[k][b], sk)
		end
		flagSet = 8'hA5;
		@(posedge clock);
		#1;
		flagSet = 8'h00;
		cpu_u.access(OP_BIT_CLR, 8'h1D, 3'h0, 8'h00, rd, sk);
		`CHK("flag clear op", 8'hA5, flagStatus)
		cpu_u.access(OP_BIT_SET, 8'h1D, 3'h2, 8'h00, rd, sk);
		`CHK("flag single bit", 8'hA1, flagStatus)
		cpu_u.access(OP_PORT_WR, 8'h1D, 3'h0, 8'h81, rd, sk);
		`CHK("flag byte write", 8'h20, flagStatus)
		for (k = 0; k < 5; k++)
			cpu_u.access(BOP[k], BAD[k], 3'h0, 8'hFF, rd, sk);
		cpu_u.access(OP_PORT_RD, 8'h10, 3'h0, 8'h00, rd, sk);
		`CHK("unused io read", 8'h00, rd)
		cpu_u.access(OP_DATA_RD, 8'h9E, 3'h0, 8'h00, rd, sk);
		`CHK("extended read", 8'h00, rd)
		for (k = 0; k < 4; k++)
		begin
			cpu_u.access(OP_PORT_RD, IOA[k], 3'h0, 8'h00, rd, sk);
			`CHK("untouched", sc[k], rd)
		end
		`CHK("flags untouched", 8'h20, flagStatus)
		// event beats a clear in one cycle
		fork
			begin
				flagSet = 8'h02;
				@(posedge clock);
				#1;
				flagSet = 8'h00;
			end
			cpu_u.access(OP_PORT_WR, 8'h1D, 3'h0, 8'h22, rd, sk);
		join
		`CHK("set beats clear", 8'h02, flagStatus)
		`CHK("strobe misses", 0, cpu_u.strobeMiss)
		wrap_up();
	end
endmodule : testbench
